// [rtl/scu_consts.svh]
// Offsets, field positions, reset values and timing counts for the card UART mode/time-unit block.
// Assumes inclusion by bare name from modules.
// Summary of operation
// RQ1: Run control bit low holds the UART in reset; set it before operation.
// RQ2: Sync select 1 moves card I/O data through bit 0 of transmit/receive registers.
// RQ3: In sync mode the card clock pin follows the manual clock level bit.
// RQ4: Host finishes the current transfer before switching sync/async mode.
// RQ5: Deselected sync card I/O floats with pull-up; new sync card takes transmit bit 0.
// RQ6: Auxiliary manual clock level bit drives no pin.
// RQ7: A status bit always shows the auxiliary interrupt input level.
// RQ8: Unmasked auxiliary input change raises the host interrupt; masked means poll only.
// RQ9: After reset all interfaces are asynchronous, select bits 0.
// RQ10: Async active card clock can stop high or low per stop and level bits.
// RQ11: Clock select 0 gives card clock, 1 twice it when divider select nonzero.
// RQ12: Divider select 000b uses single-rate clock; clock select has no effect.
// RQ13: Prescaler divides by 31 when prescale bit 0, 32 when 1.
// RQ14: Prescaler output clocks 8-bit down counter reloading from divider register.
// RQ15: All async character timing points are counted in time units.
// RQ16: Host sets time unit to F/D card clocks, default F 372 D 1.
// RQ17: Host keeps card clock between 1MHz and 5MHz by default.
// RQ18: Host keeps default factors until PPS or per specific-mode rules.
// RQ19: Host picks prescale and divider so their product equals F.
// RQ20: Host decodes baud adjustment codes; other codes reserved.
// RQ21: Down counter gives one-cycle tick and reloads at zero.
`ifndef SCU_CONSTS_SVH
`define SCU_CONSTS_SVH
`define SCU_ADDR_CSR 8'h00
`define SCU_ADDR_CCR0 8'h04
`define SCU_ADDR_CCR1 8'h08
`define SCU_ADDR_AUX_CLOCK_CONTROL 8'h0C
`define SCU_ADDR_UART_CONTROL_TWO 8'h10
`define SCU_ADDR_PDR 8'h14
`define SCU_ADDR_UTR 8'h18
`define SCU_ADDR_URR 8'h1C
`define SCU_ADDR_MSR 8'h20
// card_select_reg fields
`define SCU_CSR_SEL_LO 0
`define SCU_CSR_RUN 3
`define SCU_CSR_SYNC_LO 4
// card_clock_control fields
`define SCU_CCR_DIV_LO 0
`define SCU_CCR_CST 3
`define SCU_CCR_SC 4
`define SCU_CCR_SHL 5
// uart_control_two fields
`define SCU_UART_CONTROL_TWO_PSC 0
`define SCU_UART_CONTROL_TWO_CKU 1
`define SCU_UART_CONTROL_TWO_MASK 2
// misc_status_reg fields
`define SCU_MSR_AUXIN 0
`define SCU_MSR_AUXCHG 1
`define SCU_MSR_RUN 2
`define SCU_PRESCALE_31 8'h1E
`define SCU_PRESCALE_32 8'h1F
`define SCU_PDR_RESET 8'h0C
`endif

// [rtl/scu_pkg.sv]
// Types shared by the card UART mode/time-unit block.
// Assumes scu_consts.svh defines the numbers.
package scu_pkg;
  typedef enum logic [1:0] {
    SCU_CARD_A = 2'b00,
    SCU_CARD_B = 2'b01,
    SCU_CARD_AUX = 2'b10
  } scu_card_e;
  typedef enum logic [1:0] {
    SCU_BUS_IDLE = 2'b00,
    SCU_BUS_WR = 2'b01,
    SCU_BUS_RD = 2'b10
  } scu_bus_e;
endpackage

// [rtl/scu_etu_if.sv]
// Carries time-unit settings and tick between top and generator.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface scu_etu_if;
  logic run;
  logic fast_sel;
  logic psc32;
  logic [7:0] reload;
  logic clk_en;
  logic clk2_en;
  logic tick;
  modport ctl (output run, fast_sel, psc32, reload, clk_en, clk2_en, input tick);
  modport gen (input run, fast_sel, psc32, reload, clk_en, clk2_en, output tick);
endinterface
`default_nettype wire

// [rtl/scu_etu_gen.sv]
// Time-unit generator: clock pick, 31/32 prescaler, 8-bit reload down counter.
// Assumes clock-rate enables arrive as one-cycle pulses on hclk.
`timescale 1ns/1ps
`default_nettype none
`include "scu_consts.svh"
module scu_etu_gen
  import scu_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Settings and tick
  scu_etu_if.gen etu
);
  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] cnt;
    logic tick;
  } scu_gen_s;
  scu_gen_s st_r;
  scu_gen_s st_nxt;
  logic base_en;
  logic [7:0] pre_top;
  assign base_en = etu.fast_sel ? etu.clk2_en : etu.clk_en; // RQ11 RQ12
  assign pre_top = etu.psc32 ? `SCU_PRESCALE_32 : `SCU_PRESCALE_31; // RQ13
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!etu.run) begin // RQ1
      st_nxt.pre = 8'h00;
      st_nxt.cnt = etu.reload;
    end else if (base_en) begin
      if (st_r.pre >= pre_top) begin
        st_nxt.pre = 8'h00;
        if (st_r.cnt <= 8'h01) begin // RQ14 RQ21
          st_nxt.cnt = etu.reload;
          st_nxt.tick = 1'b1; // RQ15
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01; // RQ14
        end
      end else begin
        st_nxt.pre = st_r.pre + 8'h01;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '{pre: 8'h00, cnt: `SCU_PDR_RESET, tick: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
  // No tick leaks out in the cycle the run bit drops
  assign etu.tick = st_r.tick && etu.run; // RQ1
endmodule // scu_etu_gen
`default_nettype wire

// [rtl/scu_uart_modes.sv]
// Top: AHB-Lite registers, card select and sync/async mode, clocks, aux handshake.
// Assumes hclk 40 MHz; card pins and aux input are asynchronous.
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "scu_consts.svh"
module scu_uart_modes
  import scu_pkg::*;
#(
  parameter int CLK_DIV = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Card A and B pins
  output logic [1:0] card_clock_pin,
  output logic [1:0] card_io_out,
  output logic [1:0] card_io_oe,
  input wire logic [1:0] card_io_in,
  // Auxiliary pins
  output logic aux_io_out,
  output logic aux_io_oe,
  input wire logic aux_io_in,
  input wire logic aux_interrupt_input,
  // Host interrupt, UART reset status and time-unit tick
  output logic host_int,
  output logic uart_rst_active,
  output logic etu_tick
);
  typedef struct packed {
    scu_bus_e ph;
    logic [7:0] addr;
    logic [7:0] card_select_reg;
    logic [5:0] ccr0;
    logic [5:0] ccr1;
    logic [5:0] aux_clock_control;
    logic [2:0] uart_control_two;
    logic [7:0] time_unit_divider_reload;
    logic utr0;
    logic urr0;
    logic [31:0] rdata;
    logic [2:0] io_s1;
    logic [2:0] io_s2;
    logic aux_s1;
    logic aux_s2;
    logic aux_d;
    logic aux_chg;
    logic [7:0] div;
    logic clk_en;
    logic clk2_en;
    logic fclk;
  } scu_top_s;
  scu_top_s st_r;
  scu_top_s st_nxt;
  scu_etu_if etu_bus ();
  scu_card_e sel;
  logic [2:0] sync_bits;
  logic sel_sync;
  logic [5:0] sel_ccr;
  logic run;
  logic io_now;

  function automatic logic [5:0] ccr_of(input scu_card_e c, input scu_top_s s);
    unique case (c)
      SCU_CARD_A: ccr_of = s.ccr0;
      SCU_CARD_B: ccr_of = s.ccr1;
      SCU_CARD_AUX: ccr_of = s.aux_clock_control;
      default: ccr_of = 6'h00;
    endcase
  endfunction

  function automatic logic pin_clock(input logic [5:0] c, input logic sync_m, input logic f,
                                     input logic r);
    if (sync_m) begin
      pin_clock = c[`SCU_CCR_SC]; // RQ3
    end else if (c[`SCU_CCR_CST] || !r) begin
      pin_clock = c[`SCU_CCR_SHL]; // RQ10
    end else begin
      pin_clock = f;
    end
  endfunction

  assign sel = scu_card_e'(st_r.card_select_reg[`SCU_CSR_SEL_LO +: 2]);
  assign sync_bits = st_r.card_select_reg[`SCU_CSR_SYNC_LO +: 3];
  assign run = st_r.card_select_reg[`SCU_CSR_RUN];
  assign sel_ccr = ccr_of(sel, st_r);
  assign sel_sync = (sel == SCU_CARD_AUX) ? sync_bits[2] : sync_bits[sel[0]];
  assign io_now = (sel == SCU_CARD_AUX) ? st_r.io_s2[2] : st_r.io_s2[sel[0]];

  always_comb begin
    st_nxt = st_r;
    st_nxt.clk_en = 1'b0;
    st_nxt.clk2_en = 1'b0;
    // Card clock from divider; doubled enable on every half period
    if (st_r.div >= 8'(CLK_DIV / 2 - 1)) begin
      st_nxt.div = 8'h00;
      st_nxt.clk2_en = 1'b1;
      // Card clock level toggles every half period; one enable per full period
      st_nxt.fclk = !st_r.fclk;
      st_nxt.clk_en = st_r.fclk;
    end else begin
      st_nxt.div = st_r.div + 8'h01;
    end
    // Synchronisers
    st_nxt.io_s1 = {aux_io_in, card_io_in};
    st_nxt.io_s2 = st_r.io_s1;
    st_nxt.aux_s1 = aux_interrupt_input;
    st_nxt.aux_s2 = st_r.aux_s1;
    st_nxt.aux_d = st_r.aux_s2;
    if (run && sel_sync) begin
      st_nxt.urr0 = io_now; // RQ2
    end
    // Bus
    st_nxt.ph = SCU_BUS_IDLE;
    if (st_r.ph == SCU_BUS_WR) begin
      unique case (st_r.addr)
        `SCU_ADDR_CSR: st_nxt.card_select_reg = hwdata[7:0]; // RQ1 RQ4
        `SCU_ADDR_CCR0: st_nxt.ccr0 = hwdata[5:0];
        `SCU_ADDR_CCR1: st_nxt.ccr1 = hwdata[5:0];
        `SCU_ADDR_AUX_CLOCK_CONTROL: st_nxt.aux_clock_control = hwdata[5:0]; // RQ6
        `SCU_ADDR_UART_CONTROL_TWO: st_nxt.uart_control_two = hwdata[2:0];
        `SCU_ADDR_PDR: st_nxt.time_unit_divider_reload = hwdata[7:0];
        `SCU_ADDR_UTR: st_nxt.utr0 = hwdata[0]; // RQ2
        default: st_nxt.card_select_reg = st_r.card_select_reg;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      st_nxt.ph = hwrite ? SCU_BUS_WR : SCU_BUS_RD;
      st_nxt.addr = haddr;
      st_nxt.rdata = 32'h0000_0000;
      if (!hwrite) begin
        unique case (haddr)
          `SCU_ADDR_CSR: st_nxt.rdata = {24'h000000, st_r.card_select_reg};
          `SCU_ADDR_CCR0: st_nxt.rdata = {26'h0000000, st_r.ccr0};
          `SCU_ADDR_CCR1: st_nxt.rdata = {26'h0000000, st_r.ccr1};
          `SCU_ADDR_AUX_CLOCK_CONTROL: st_nxt.rdata = {26'h0000000, st_r.aux_clock_control};
          `SCU_ADDR_UART_CONTROL_TWO: st_nxt.rdata = {29'h00000000, st_r.uart_control_two};
          `SCU_ADDR_PDR: st_nxt.rdata = {24'h000000, st_r.time_unit_divider_reload};
          `SCU_ADDR_UTR: st_nxt.rdata = {31'h00000000, st_r.utr0};
          `SCU_ADDR_URR: st_nxt.rdata = {31'h00000000, st_r.urr0}; // RQ2
          `SCU_ADDR_MSR: st_nxt.rdata = {29'h00000000, run, st_r.aux_chg, st_r.aux_s2}; // RQ7
          default: st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Sticky aux change; set wins over clear on status read
    if (st_r.ph == SCU_BUS_RD && st_r.addr == `SCU_ADDR_MSR) begin
      st_nxt.aux_chg = 1'b0;
    end
    if (st_r.aux_s2 != st_r.aux_d) begin
      st_nxt.aux_chg = 1'b1; // RQ8
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0; // RQ9
      st_r.time_unit_divider_reload <= `SCU_PDR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Time-unit generator settings
  assign etu_bus.run = run;
  assign etu_bus.fast_sel = st_r.uart_control_two[`SCU_UART_CONTROL_TWO_CKU] && (sel_ccr[2:0] != 3'b000); // RQ11 RQ12
  assign etu_bus.psc32 = st_r.uart_control_two[`SCU_UART_CONTROL_TWO_PSC];
  assign etu_bus.reload = st_r.time_unit_divider_reload;
  assign etu_bus.clk_en = st_r.clk_en;
  assign etu_bus.clk2_en = st_r.clk2_en;

  scu_etu_gen u_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .etu(etu_bus.gen)
  );

  // Pins
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_card
      assign card_clock_pin[gi] = pin_clock(gi ? st_r.ccr1 : st_r.ccr0, sync_bits[gi],
                                            st_r.fclk, run);
      // Selected sync card drives transmit bit 0; others float with pull-up
      assign card_io_out[gi] = st_r.utr0; // RQ5
      assign card_io_oe[gi] = run && sync_bits[gi] && (sel == scu_card_e'(gi)) && !st_r.utr0;
    end
  endgenerate
  assign aux_io_out = st_r.utr0;
  assign aux_io_oe = run && sync_bits[2] && (sel == SCU_CARD_AUX) && !st_r.utr0; // RQ5
  assign host_int = st_r.aux_chg && !st_r.uart_control_two[`SCU_UART_CONTROL_TWO_MASK]; // RQ8
  assign uart_rst_active = !run; // RQ1
  assign etu_tick = etu_bus.tick;
  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule // scu_uart_modes
`default_nettype wire

// [verif/scu_uart_modes_props.sv]
// Checker for the card UART mode and time-unit top.
// Assumes it is bound to scu_uart_modes from the testbench.
`timescale 1ns/1ps
`default_nettype none
module scu_uart_modes_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Watched outputs
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [1:0] card_clock_pin,
  input wire logic [1:0] card_io_out,
  input wire logic [1:0] card_io_oe,
  input wire logic aux_io_out,
  input wire logic aux_io_oe,
  input wire logic host_int,
  input wire logic uart_rst_active,
  input wire logic etu_tick
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_tick_spacing: assert property (etu_tick |=> !etu_tick [*8])
    else $error("tick too close");
  chk_no_tick_rst: assert property (uart_rst_active |-> !etu_tick)
    else $error("tick while held");
  chk_io_drive_low: assert property (card_io_oe[0] |-> !card_io_out[0])
    else $error("card io drives high");
  chk_aux_drive_low: assert property (aux_io_oe |-> !aux_io_out)
    else $error("aux io drives high");
  chk_one_io_owner: assert property (card_io_oe != 2'b11)
    else $error("both card io driven");
  chk_held_clk_stable: assert property (uart_rst_active && $past(uart_rst_active) |->
    $stable(card_clock_pin))
    else $error("clock moves while held");
  cov_tick: cover property (etu_tick);
  cov_int: cover property ($rose(host_int));
  cov_io_b: cover property (card_io_oe[1]);
endmodule // scu_uart_modes_props
`default_nettype wire

// [verif/scu_card_model.sv]
// Card-side model: open-drain I/O lines with pull-ups, card may pull line A low.
// Assumes the block drives low only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module scu_card_model (
  // Block side
  input wire logic [1:0] io_out,
  input wire logic [1:0] io_oe,
  input wire logic aux_out,
  input wire logic aux_oe,
  // Card side
  input wire logic card_pull,
  output logic [1:0] io_in,
  output logic aux_in
);
  assign io_in[0] = !((io_oe[0] && !io_out[0]) || card_pull);
  assign io_in[1] = !(io_oe[1] && !io_out[1]);
  assign aux_in = !(aux_oe && !aux_out);
endmodule // scu_card_model
`default_nettype wire

// [verif/smartcard_uart_modes_etu_gen_test.sv]
// Testbench for the card UART mode and time-unit block.
// Assumes design, card model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "scu_consts.svh"
module smartcard_uart_modes_etu_gen_test;
  logic hclk, hresetn, hsel, hwrite, aux_int, card_pull, aux_in;
  logic [7:0] haddr;
  logic [1:0] htrans, clk_pin, io_out, io_oe, io_in;
  logic [31:0] hwdata, hrdata, q;
  logic hreadyout, hresp, aux_out, aux_oe, host_int, rst_act, etu_tick;
  int n_errors = 0, n_tests = 0, cyc = 0;
  scu_uart_modes #(.CLK_DIV(8)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .card_clock_pin(clk_pin), .card_io_out(io_out), .card_io_oe(io_oe), .card_io_in(io_in),
    .aux_io_out(aux_out), .aux_io_oe(aux_oe), .aux_io_in(aux_in),
    .aux_interrupt_input(aux_int), .host_int(host_int), .uart_rst_active(rst_act),
    .etu_tick(etu_tick));
  scu_card_model u_card (.io_out(io_out), .io_oe(io_oe), .aux_out(aux_out), .aux_oe(aux_oe),
    .card_pull(card_pull), .io_in(io_in), .aux_in(aux_in));
  initial begin
    hclk = 0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      end_sim;
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    @(negedge hclk);
  endtask
  task automatic per(input int e);
    int n;
    n = 0;
    repeat (2) @(posedge hclk iff etu_tick === 1'b1);
    do begin @(posedge hclk); n++; end while (etu_tick !== 1'b1);
    cmp("etu period", e, n);
  endtask
  task automatic t_reset;
    bus(0, `SCU_ADDR_CSR, 0); cmp("csr", 0, q);
    bus(0, `SCU_ADDR_PDR, 0); cmp("pdr", 32'h0C, q);
    cmp("held", 1, rst_act);
    bus(0, 8'h40, 0); cmp("unmapped", 0, q);
  endtask
  task automatic t_sync;
    bus(1, `SCU_ADDR_CSR, 32'h18); cmp("held", 0, rst_act);
    bus(1, `SCU_ADDR_CCR0, 32'h10); cmp("clk a", 1, clk_pin[0]);
    bus(1, `SCU_ADDR_CCR0, 0); cmp("clk a", 0, clk_pin[0]);
    bus(1, `SCU_ADDR_UTR, 0); cmp("oe a", 1, io_oe[0]);
    bus(1, `SCU_ADDR_UTR, 1); cmp("oe a", 0, io_oe[0]);
    @(posedge hclk); card_pull <= 1;
    repeat (5) @(posedge hclk);
    bus(0, `SCU_ADDR_URR, 0); cmp("urr", 0, q[0]);
    card_pull <= 0;
    repeat (4) @(posedge hclk);
    bus(0, `SCU_ADDR_URR, 0);
    cmp("urr high", 1, q[0]);
    bus(1, `SCU_ADDR_UTR, 0); bus(1, `SCU_ADDR_CSR, 32'h39);
    cmp("oe", 2'h2, io_oe);
    cmp("io a", 1, io_in[0]);
  endtask
  task automatic t_stop;
    bus(1, `SCU_ADDR_CSR, 32'h08); bus(1, `SCU_ADDR_CCR0, 32'h28);
    repeat (3) begin repeat (7) @(negedge hclk); cmp("stop hi", 1, clk_pin[0]); end
    bus(1, `SCU_ADDR_CCR0, 32'h08);
    repeat (3) begin repeat (7) @(negedge hclk); cmp("stop lo", 0, clk_pin[0]); end
  endtask
  task automatic t_aux;
    bus(1, `SCU_ADDR_CCR1, 32'h08); bus(1, `SCU_ADDR_CSR, 32'h4A);
    cmp("aux pin", 2'h1, {aux_out, aux_oe});
    cmp("oe", 0, io_oe);
    bus(1, `SCU_ADDR_AUX_CLOCK_CONTROL, 32'h10); cmp("aux clk", 0, clk_pin);
    bus(1, `SCU_ADDR_UART_CONTROL_TWO, 0); bus(0, `SCU_ADDR_MSR, 0);
    @(posedge hclk); aux_int <= 1;
    repeat (6) @(negedge hclk);
    cmp("int", 1, host_int);
    bus(0, `SCU_ADDR_MSR, 0); cmp("msr", 3'h7, q[2:0]);
    cmp("int clr", 0, host_int);
    bus(1, `SCU_ADDR_UART_CONTROL_TWO, 32'h4);
    @(posedge hclk); aux_int <= 0;
    repeat (6) @(negedge hclk);
    cmp("int mask", 0, host_int);
    bus(0, `SCU_ADDR_MSR, 0); cmp("msr", 3'h6, q[2:0]);
  endtask
  task automatic t_etu;
    int k;
    bus(1, `SCU_ADDR_CSR, 32'h08); bus(1, `SCU_ADDR_CCR0, 0);
    bus(1, `SCU_ADDR_UART_CONTROL_TWO, 0);
    @(posedge clk_pin[0]);
    k = cyc;
    @(posedge clk_pin[0]);
    cmp("clk period", 8, cyc - k);
    per(31 * 12 * 8);
    bus(1, `SCU_ADDR_PDR, 2);
    per(31 * 2 * 8);
    bus(1, `SCU_ADDR_UART_CONTROL_TWO, 1); per(32 * 2 * 8);
    bus(1, `SCU_ADDR_UART_CONTROL_TWO, 2); per(31 * 2 * 8);
    bus(1, `SCU_ADDR_CCR0, 1); per(31 * 2 * 4);
    bus(1, `SCU_ADDR_CSR, 0); cmp("held", 1, rst_act);
    repeat (600) @(posedge hclk);
  endtask
  initial begin
    hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    aux_int = 0; card_pull = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    t_reset; t_sync; t_stop; t_aux; t_etu;
    end_sim;
  end
endmodule // smartcard_uart_modes_etu_gen_test
bind scu_uart_modes scu_uart_modes_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .card_clock_pin(card_clock_pin),
  .card_io_out(card_io_out), .card_io_oe(card_io_oe), .aux_io_out(aux_io_out),
  .aux_io_oe(aux_io_oe), .host_int(host_int), .uart_rst_active(uart_rst_active),
  .etu_tick(etu_tick));
`default_nettype wire
